//--- design/fpos_pkg.sv
/*
  Constants, encodings and state type for the flash program-once sequencer.
  Assumes every user writes package::name and imports nothing.
*/
package fpos_pkg;

  // Command word geometry
  localparam int WORD_W = 16;
  localparam int NUM_WORDS = 6;
  localparam int PHRASE_W = 64;
  localparam int GADDR_W = 24;

  // Command codes held in word 0 bits [15:8]
  localparam logic [7:0] CMD_READ_ONCE = 8'h04;
  localparam logic [7:0] CMD_PROGRAM = 8'h06;
  localparam logic [7:0] CMD_PROGRAM_ONCE = 8'h07;

  // Index register value expected at launch
  localparam logic [2:0] IDX_READ_ONCE = 3'h1;
  localparam logic [2:0] IDX_PROGRAM = 3'h5;

  // One-time field: 64 bytes as 8 phrases, indices 0x0000 to 0x0007
  localparam int ONCE_BYTES = 64;
  localparam int ONCE_PHRASES = 8;
  localparam logic [15:0] ONCE_IDX_MIN = 16'h0000;
  localparam logic [15:0] ONCE_IDX_MAX = 16'h0007;

  // Phrase alignment: global address bits [2:0] must be zero
  localparam logic [2:0] PHRASE_ALIGN = 3'h0;
  localparam logic [63:0] ERASED_PHRASE = 64'hFFFF_FFFF_FFFF_FFFF;

  // Default program flash window, global byte addresses
  localparam logic [23:0] PF_LO_DEF = 24'hFE_0000;
  localparam logic [23:0] PF_HI_DEF = 24'hFF_FFFF;

  // Values after reset
  localparam logic COMPLETE_RST = 1'b1;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [2:0] IDX_RST = 3'h0;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_BLANK = 3'b010,
    ST_PROGRAM = 3'b011,
    ST_VERIFY = 3'b100,
    ST_READ = 3'b101
  } fpos_state_t;

endpackage

//--- design/fpos_cmd_words.sv
/*
  Indexed command word registers: software writes one word per strobe,
  the sequencer loads words two to five with a fetched phrase.
  Assumes both writers sit on the same clock and never write in one cycle
  (the sequencer only loads while software writes are blocked).
*/
`timescale 1ns/1ps
`default_nettype none

module fpos_cmd_words #(
  parameter int WORD_W = 16,
  parameter int NUM_WORDS = 6
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic swWrite,
  input wire logic [2:0] swIdx,
  input wire logic [WORD_W-1:0] swData,
  input wire logic seqLoad,
  input wire logic [4*WORD_W-1:0] seqPhrase,
  input wire logic [2:0] rdIdx,
  output logic [NUM_WORDS*WORD_W-1:0] wordsFlat,
  output logic [WORD_W-1:0] rdData
);

  logic [WORD_W-1:0] words_q [NUM_WORDS];
  logic [WORD_W-1:0] words_d [NUM_WORDS];
  logic [WORD_W-1:0] rdData_d;
  logic [WORD_W-1:0] rdData_q;

  // Next word values; sequencer load takes words 2..5, word 2 = top of phrase
  always_comb
  begin
    for (int i = 0; i < NUM_WORDS; i++)
    begin
      words_d[i] = words_q[i];
    end
    if (swWrite && (int'(swIdx) < NUM_WORDS))
    begin
      words_d[swIdx] = swData;
    end
    if (seqLoad)
    begin
      for (int i = 0; i < 4; i++)
      begin
        words_d[2 + i] = seqPhrase[(3 - i)*WORD_W +: WORD_W];
      end
    end
    // Out-of-range index reads as zero
    rdData_d = (int'(rdIdx) < NUM_WORDS) ? words_d[rdIdx] : fpos_pkg::WORD_RST;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_WORDS; i++)
      begin
        words_q[i] <= fpos_pkg::WORD_RST;
      end
      rdData_q <= fpos_pkg::WORD_RST;
    end
    else
    begin
      for (int i = 0; i < NUM_WORDS; i++)
      begin
        words_q[i] <= words_d[i];
      end
      rdData_q <= rdData_d;
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_WORDS; i++)
    begin
      wordsFlat[i*WORD_W +: WORD_W] = words_q[i];
    end
  end

  assign rdData = rdData_q;

endmodule

`default_nettype wire

//--- design/fpos_sequencer.sv
/*
  Command sequencer for read-once, program-phrase and program-once.
  Assumes a same-clock flash array port: request held until a one-cycle
  acknowledge, read data and error flags valid with that acknowledge.
  Software strobes come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module fpos_sequencer #(
  parameter logic [23:0] PF_LO = fpos_pkg::PF_LO_DEF,
  parameter logic [23:0] PF_HI = fpos_pkg::PF_HI_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cmdWrite,
  input wire logic [2:0] cmdWordIdxIn,
  input wire logic [15:0] cmdWordData,
  input wire logic cmdLaunch,
  input wire logic clrAccessErr,
  input wire logic clrProtectViol,
  input wire logic onceCmdAllowed,
  input wire logic progCmdAllowed,
  input wire logic protEnable,
  input wire logic [17:0] protLo,
  input wire logic [17:0] protHi,
  input wire logic flashAck,
  input wire logic [63:0] flashRdata,
  input wire logic flashErr,
  input wire logic flashFatal,
  output logic cmdCompleteFlag,
  output logic accessErrorFlag,
  output logic protectViolationFlag,
  output logic verifyStatusHi,
  output logic verifyStatusLo,
  output logic [2:0] cmdWordIdx,
  output logic [15:0] cmdWordRdata,
  output logic flashReq,
  output logic flashProg,
  output logic flashInfo,
  output logic [23:0] flashAddr,
  output logic [63:0] flashWdata,
  output logic pfReadInvalid
);

  fpos_pkg::fpos_state_t state_q, state_d;
  logic complete_q, complete_d;
  logic access_error_flag_q, access_error_flag_d;
  logic protViol_q, protViol_d;
  logic verHi_q, verHi_d;
  logic verLo_q, verLo_d;
  logic [2:0] idx_q, idx_d;
  logic [23:0] addr_q, addr_d;
  logic isOnce_q, isOnce_d;
  logic setAcc;
  logic setProt;
  logic seqLoad;
  logic swWrite;
  logic checkBad;
  logic protHit;
  logic [95:0] wordsFlat;
  logic [15:0] word0;
  logic [15:0] word1;
  logic [7:0] code;
  logic [23:0] gaddr;

  // Known command codes of this sequencer
  function automatic logic knownCode(input logic [7:0] c);
    return (c == fpos_pkg::CMD_READ_ONCE) || (c == fpos_pkg::CMD_PROGRAM) ||
           (c == fpos_pkg::CMD_PROGRAM_ONCE);
  endfunction

  // Phrase index inside the eight-phrase one-time field
  function automatic logic onceIdxOk(input logic [15:0] w);
    return (w >= fpos_pkg::ONCE_IDX_MIN) && (w <= fpos_pkg::ONCE_IDX_MAX);
  endfunction

  // Software writes land only while idle, so busy commands keep their words
  assign swWrite = cmdWrite && complete_q;

  fpos_cmd_words #(
    .WORD_W(fpos_pkg::WORD_W),
    .NUM_WORDS(fpos_pkg::NUM_WORDS)
  ) u_words (
    .clk(clk),
    .rstn(rstn),
    .swWrite(swWrite),
    .swIdx(cmdWordIdxIn),
    .swData(cmdWordData),
    .seqLoad(seqLoad),
    .seqPhrase(flashRdata),
    .rdIdx(idx_d),
    .wordsFlat(wordsFlat),
    .rdData(cmdWordRdata)
  );

  // Field decode of the loaded command words
  assign word0 = wordsFlat[15:0];
  assign word1 = wordsFlat[31:16];
  assign code = word0[15:8];
  assign gaddr = {word0[7:0], word1};
  assign protHit = protEnable && (gaddr[17:0] >= protLo) && (gaddr[17:0] <= protHi);

  // Launch-time checks per command; an unknown code always fails
  always_comb
  begin
    case (code)
      fpos_pkg::CMD_READ_ONCE:
      begin
        checkBad = (idx_q != fpos_pkg::IDX_READ_ONCE) || !onceCmdAllowed || !onceIdxOk(word1);
      end
      fpos_pkg::CMD_PROGRAM:
      begin
        checkBad = (idx_q != fpos_pkg::IDX_PROGRAM) || !progCmdAllowed ||
                   (gaddr < PF_LO) || (gaddr > PF_HI) ||
                   (gaddr[2:0] != fpos_pkg::PHRASE_ALIGN);
      end
      fpos_pkg::CMD_PROGRAM_ONCE:
      begin
        checkBad = (idx_q != fpos_pkg::IDX_PROGRAM) || !onceCmdAllowed || !onceIdxOk(word1);
      end
      default:
      begin
        checkBad = 1'b1;
      end
    endcase
  end

  // Sequencer next state and status flags
  always_comb
  begin
    state_d = state_q;
    complete_d = complete_q;
    verHi_d = verHi_q;
    verLo_d = verLo_q;
    idx_d = idx_q;
    addr_d = addr_q;
    isOnce_d = isOnce_q;
    setAcc = 1'b0;
    setProt = 1'b0;
    seqLoad = 1'b0;
    if (swWrite)
    begin
      idx_d = cmdWordIdxIn;
      if ((cmdWordIdxIn == 3'h0) && !knownCode(cmdWordData[15:8]))
      begin
        setAcc = 1'b1;
      end
    end
    case (state_q)
      fpos_pkg::ST_IDLE:
      begin
        // Pending access or protection flag blocks the launch
        if (cmdLaunch && complete_q && !access_error_flag_q && !protViol_q)
        begin
          complete_d = 1'b0;
          verHi_d = 1'b0;
          verLo_d = 1'b0;
          state_d = fpos_pkg::ST_CHECK;
        end
      end
      fpos_pkg::ST_CHECK:
      begin
        if (checkBad)
        begin
          setAcc = 1'b1;
          complete_d = 1'b1;
          state_d = fpos_pkg::ST_IDLE;
        end
        else if ((code == fpos_pkg::CMD_PROGRAM) && protHit)
        begin
          setProt = 1'b1;
          complete_d = 1'b1;
          state_d = fpos_pkg::ST_IDLE;
        end
        else
        begin
          // Once commands address the info row at phrase granularity
          isOnce_d = (code != fpos_pkg::CMD_PROGRAM);
          addr_d = (code == fpos_pkg::CMD_PROGRAM) ? gaddr : {18'h0_0000, word1[2:0], 3'h0};
          if (code == fpos_pkg::CMD_READ_ONCE)
          begin
            state_d = fpos_pkg::ST_READ;
          end
          else if (code == fpos_pkg::CMD_PROGRAM)
          begin
            state_d = fpos_pkg::ST_PROGRAM;
          end
          else
          begin
            state_d = fpos_pkg::ST_BLANK;
          end
        end
      end
      fpos_pkg::ST_BLANK:
      begin
        if (flashAck)
        begin
          // All ones reads as blank, so an all-ones phrase may be reprogrammed
          if (flashRdata == fpos_pkg::ERASED_PHRASE)
          begin
            state_d = fpos_pkg::ST_PROGRAM;
          end
          else
          begin
            setAcc = 1'b1;
            complete_d = 1'b1;
            state_d = fpos_pkg::ST_IDLE;
          end
        end
      end
      fpos_pkg::ST_PROGRAM:
      begin
        if (flashAck)
        begin
          state_d = fpos_pkg::ST_VERIFY;
        end
      end
      fpos_pkg::ST_VERIFY:
      begin
        if (flashAck)
        begin
          // Data mismatch counts as a correctable verify error
          verHi_d = flashErr || flashFatal || (flashRdata != flashWdata);
          verLo_d = flashFatal;
          complete_d = 1'b1;
          state_d = fpos_pkg::ST_IDLE;
        end
      end
      fpos_pkg::ST_READ:
      begin
        if (flashAck)
        begin
          seqLoad = 1'b1;
          verHi_d = flashErr || flashFatal;
          verLo_d = flashFatal;
          complete_d = 1'b1;
          state_d = fpos_pkg::ST_IDLE;
        end
      end
      default:
      begin
        complete_d = 1'b1;
        state_d = fpos_pkg::ST_IDLE;
      end
    endcase
    // Set beats clear in the same cycle
    access_error_flag_d = (access_error_flag_q && !clrAccessErr) || setAcc;
    protViol_d = (protViol_q && !clrProtectViol) || setProt;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= fpos_pkg::ST_IDLE;
      complete_q <= fpos_pkg::COMPLETE_RST;
      access_error_flag_q <= fpos_pkg::FLAG_RST;
      protViol_q <= fpos_pkg::FLAG_RST;
      verHi_q <= fpos_pkg::FLAG_RST;
      verLo_q <= fpos_pkg::FLAG_RST;
      idx_q <= fpos_pkg::IDX_RST;
      addr_q <= 24'h00_0000;
      isOnce_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      complete_q <= complete_d;
      access_error_flag_q <= access_error_flag_d;
      protViol_q <= protViol_d;
      verHi_q <= verHi_d;
      verLo_q <= verLo_d;
      idx_q <= idx_d;
      addr_q <= addr_d;
      isOnce_q <= isOnce_d;
    end
  end

  // Flash port; request is combinational from the state, held until ack
  assign flashReq = (state_q == fpos_pkg::ST_BLANK) || (state_q == fpos_pkg::ST_PROGRAM) ||
                    (state_q == fpos_pkg::ST_VERIFY) || (state_q == fpos_pkg::ST_READ);
  assign flashProg = (state_q == fpos_pkg::ST_PROGRAM);
  assign flashInfo = isOnce_q;
  assign flashAddr = addr_q;
  assign flashWdata = wordsFlat[95:32] == 64'h0 ? 64'h0 :
                      {wordsFlat[47:32], wordsFlat[63:48], wordsFlat[79:64], wordsFlat[95:80]};
  // Array is busy on the info row; program flash reads are not trustworthy
  assign pfReadInvalid = flashReq && isOnce_q;

  assign cmdCompleteFlag = complete_q;
  assign accessErrorFlag = access_error_flag_q;
  assign protectViolationFlag = protViol_q;
  assign verifyStatusHi = verHi_q;
  assign verifyStatusLo = verLo_q;
  assign cmdWordIdx = idx_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  launch_clears_done_a: assert property ((state_q == fpos_pkg::ST_IDLE) && cmdLaunch && complete_q &&
      !access_error_flag_q && !protViol_q |=> !cmdCompleteFlag)
    else $error("Launch did not clear completion");

  bad_code_write_a: assert property (swWrite && (cmdWordIdxIn == 3'h0) &&
      !knownCode(cmdWordData[15:8]) |=> accessErrorFlag)
    else $error("Undefined code did not raise access error");

  read_once_index_a: assert property ((state_q == fpos_pkg::ST_CHECK) && (code == fpos_pkg::CMD_READ_ONCE) &&
      (word1 > fpos_pkg::ONCE_IDX_MAX) |=> accessErrorFlag && cmdCompleteFlag && !flashReq)
    else $error("Bad read-once index not refused");

  prog_align_a: assert property ((state_q == fpos_pkg::ST_CHECK) && (code == fpos_pkg::CMD_PROGRAM) &&
      (gaddr[2:0] != 3'h0) |=> accessErrorFlag ##1 !flashProg)
    else $error("Misaligned program not refused");

  prot_no_program_a: assert property ((state_q == fpos_pkg::ST_CHECK) && !checkBad &&
      (code == fpos_pkg::CMD_PROGRAM) && protHit |=> protectViolationFlag && !flashReq && cmdCompleteFlag)
    else $error("Protected program went ahead");

  program_then_verify_a: assert property (flashProg && flashAck |=> flashReq && !flashProg &&
      (flashAddr == $past(flashAddr)) && !cmdCompleteFlag)
    else $error("Program not followed by read-back");

  once_blocks_read_a: assert property ((state_q == fpos_pkg::ST_READ) ||
      ((state_q == fpos_pkg::ST_PROGRAM) && flashInfo) |-> pfReadInvalid && !cmdCompleteFlag)
    else $error("Program flash read not flagged during once command");

  verify_mismatch_a: assert property ((state_q == fpos_pkg::ST_VERIFY) && flashAck &&
      (flashRdata != flashWdata) |=> verifyStatusHi && cmdCompleteFlag)
    else $error("Verify mismatch not reported");

  once_reprogram_a: assert property ((state_q == fpos_pkg::ST_BLANK) && flashAck &&
      (flashRdata != fpos_pkg::ERASED_PHRASE) |=> (accessErrorFlag && !flashReq) [*2])
    else $error("Programmed phrase was programmed again");

  read_once_fatal_a: assert property ((state_q == fpos_pkg::ST_READ) && flashAck && flashFatal
      |=> verifyStatusHi && verifyStatusLo && !protectViolationFlag)
    else $error("Read-once fatal error not reported");

endmodule

`default_nettype wire

//--- test/fpos_sequencer_tb.sv
/*
  Self-checking bench for the flash program-once sequencer: plays software
  and the flash array, predicts every flag from its own model.
  Assumes the design's default program flash window and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin totalChecks++; if ((gt) !== (ex)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end

module fpos_sequencer_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmdWrite = 1'b0;
  logic cmdLaunch = 1'b0;
  logic clrAccessErr = 1'b0;
  logic clrProtectViol = 1'b0;
  logic onceCmdAllowed = 1'b1;
  logic progCmdAllowed = 1'b1;
  logic protEnable = 1'b0;
  logic flashAck = 1'b0;
  logic flashErr = 1'b0;
  logic flashFatal = 1'b0;
  logic [2:0] cmdWordIdxIn = 3'h0;
  logic [15:0] cmdWordData = 16'h0000;
  logic [17:0] protLo = 18'h2_0100;
  logic [17:0] protHi = 18'h2_01ff;
  logic [63:0] flashRdata = 64'h0000_0000_0000_0000;
  logic cmdCompleteFlag, accessErrorFlag, protectViolationFlag, verifyStatusHi, verifyStatusLo;
  logic flashReq, flashProg, flashInfo, pfReadInvalid;
  logic [2:0] cmdWordIdx;
  logic [15:0] cmdWordRdata;
  logic [23:0] flashAddr;
  logic [63:0] flashWdata;
  int miscompares = 0;
  int totalChecks = 0;
  int ackCount = 0;
  int lat = 0;
  integer seed = 32'h178d_ed5b;
  logic [63:0] infoMem [8] = '{default: '1};
  logic [63:0] pfMem [int];
  logic injErr = 1'b0;
  logic injFatal = 1'b0;
  logic injBad = 1'b0;
  logic expInfo = 1'b0;
  logic [23:0] expAddr = 24'h00_0000;
  logic [63:0] expData = 64'h0000_0000_0000_0000;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  fpos_sequencer uut (.clk(clk), .rstn(rstn), .cmdWrite(cmdWrite), .cmdWordIdxIn(cmdWordIdxIn),
    .cmdWordData(cmdWordData), .cmdLaunch(cmdLaunch), .clrAccessErr(clrAccessErr),
    .clrProtectViol(clrProtectViol), .onceCmdAllowed(onceCmdAllowed), .progCmdAllowed(progCmdAllowed),
    .protEnable(protEnable), .protLo(protLo), .protHi(protHi), .flashAck(flashAck),
    .flashRdata(flashRdata), .flashErr(flashErr), .flashFatal(flashFatal),
    .cmdCompleteFlag(cmdCompleteFlag), .accessErrorFlag(accessErrorFlag),
    .protectViolationFlag(protectViolationFlag), .verifyStatusHi(verifyStatusHi),
    .verifyStatusLo(verifyStatusLo), .cmdWordIdx(cmdWordIdx), .cmdWordRdata(cmdWordRdata),
    .flashReq(flashReq), .flashProg(flashProg), .flashInfo(flashInfo), .flashAddr(flashAddr),
    .flashWdata(flashWdata), .pfReadInvalid(pfReadInvalid));

  // Flash array stand-in; idle read data toggles so stale data never looks valid
  always @(negedge clk)
  begin
    if (flashReq)
      `CHK("pfReadInvalid", expInfo, pfReadInvalid)
    if (flashReq && !flashAck && lat <= 0)
    begin
      flashAck <= 1'b1;
      ackCount++;
      `CHK("flashAddr", expAddr, flashAddr)
      `CHK("flashInfo", expInfo, flashInfo)
      if (flashProg)
      begin
        `CHK("flashWdata", expData, flashWdata)
        if (flashInfo)
          infoMem[flashAddr[5:3]] = flashWdata ^ 64'(injBad);
        else
          pfMem[int'(flashAddr)] = flashWdata ^ 64'(injBad);
        flashRdata <= ~flashRdata;
      end
      else
      begin
        flashRdata <= flashInfo ? infoMem[flashAddr[5:3]] :
          (pfMem.exists(int'(flashAddr)) ? pfMem[int'(flashAddr)] : '1);
        flashErr <= injErr;
        flashFatal <= injFatal;
      end
      lat = $unsigned($random(seed)) % 4;
    end
    else
    begin
      flashAck <= 1'b0;
      flashErr <= 1'b0;
      flashFatal <= 1'b0;
      flashRdata <= ~flashRdata;
      if (flashReq && !flashAck)
        lat--;
    end
  end

  task automatic testDone();
    if (miscompares == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One software word write, index register and readback checked after
  task automatic wrWord(input logic [2:0] idx, input logic [15:0] dat);
    @(negedge clk);
    cmdWrite = 1'b1;
    cmdWordIdxIn = idx;
    cmdWordData = dat;
    @(negedge clk);
    cmdWrite = 1'b0;
    `CHK("cmdWordIdx", idx, cmdWordIdx)
    `CHK("cmdWordRdata", (idx < 3'h6) ? dat : 16'h0000, cmdWordRdata)
  endtask

  task automatic pulseClr();
    @(negedge clk);
    clrAccessErr = 1'b1;
    clrProtectViol = 1'b1;
    @(negedge clk);
    clrAccessErr = 1'b0;
    clrProtectViol = 1'b0;
  endtask

  // Model predicts flags and flash traffic, then runs the command
  task automatic doCmd(input logic [7:0] code, input logic [7:0] aHi, input logic [15:0] w1,
                       input logic [63:0] d, input logic [2:0] last);
    logic expAcc, expProt, expHi, expLo;
    logic [63:0] rdExp;
    int expAcks, a, n;
    a = {aHi, w1};
    expAcc = 1'b0;
    expProt = 1'b0;
    expHi = injErr | injFatal;
    expLo = injFatal;
    expAcks = 0;
    expData = d;
    expInfo = (code != fpos_pkg::CMD_PROGRAM);
    expAddr = expInfo ? {5'h00, w1, 3'h0} : a[23:0];
    rdExp = infoMem[w1[2:0]];
    if (code == fpos_pkg::CMD_READ_ONCE)
    begin
      if (last != 3'h1 || !onceCmdAllowed || w1 > 16'h0007)
        expAcc = 1'b1;
      else
        expAcks = 1;
    end
    else if (code == fpos_pkg::CMD_PROGRAM)
    begin
      if (last != 3'h5 || !progCmdAllowed || a < 32'h00fe_0000 || a[2:0] != 3'h0)
        expAcc = 1'b1;
      else if (protEnable && a[17:0] >= protLo && a[17:0] <= protHi)
        expProt = 1'b1;
      else
        expAcks = 2;
    end
    else if (last != 3'h5 || !onceCmdAllowed || w1 > 16'h0007)
      expAcc = 1'b1;
    else if (infoMem[w1[2:0]] !== '1)
    begin
      expAcc = 1'b1;
      expAcks = 1;
    end
    else
      expAcks = 3;
    if (expAcks > 1)
      expHi = expHi | injBad;
    if (expAcc || expProt)
    begin
      expHi = 1'b0;
      expLo = 1'b0;
    end
    // Reused target is erased in the array model first, so only erased phrases get programmed
    if (code == fpos_pkg::CMD_PROGRAM && pfMem.exists(a))
      pfMem.delete(a);
    wrWord(3'h0, {code, aHi});
    for (n = 1; n <= last; n++)
      wrWord(n[2:0], (n == 1 || n > 5) ? w1 : d[(5 - n) * 16 +: 16]);
    ackCount = 0;
    @(negedge clk);
    cmdLaunch = 1'b1;
    @(negedge clk);
    cmdLaunch = 1'b0;
    `CHK("cmdCompleteFlag", 1'b0, cmdCompleteFlag)
    // Write while busy must be dropped
    cmdWrite = 1'b1;
    cmdWordIdxIn = 3'h0;
    @(negedge clk);
    cmdWrite = 1'b0;
    for (n = 0; n < 200 && cmdCompleteFlag !== 1'b1; n++)
      @(negedge clk);
    if (cmdCompleteFlag !== 1'b1)
    begin
      miscompares++;
      testDone();
    end
    `CHK("cmdWordIdx", last, cmdWordIdx)
    `CHK("accessErrorFlag", expAcc, accessErrorFlag)
    `CHK("protectViolationFlag", expProt, protectViolationFlag)
    `CHK("verifyStatusHi", expHi, verifyStatusHi)
    `CHK("verifyStatusLo", expLo, verifyStatusLo)
    `CHK("flashAcks", expAcks, ackCount)
    if (code == fpos_pkg::CMD_READ_ONCE && expAcks == 1)
      `CHK("readPhrase", rdExp, flashWdata)
    repeat (3) @(negedge clk);
    `CHK("heldAccess", expAcc, accessErrorFlag)
    pulseClr();
    `CHK("clearedAccess", 1'b0, accessErrorFlag)
    `CHK("clearedProtect", 1'b0, protectViolationFlag)
    `CHK("heldVerifyHi", expHi, verifyStatusHi)
  endtask

  initial
  begin
    int i;
    logic [31:0] r;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    `CHK("resetComplete", 1'b1, cmdCompleteFlag)
    `CHK("resetAccess", 1'b0, accessErrorFlag)
    // Undefined code flags at once, launch then refused
    wrWord(3'h0, 16'h0500);
    `CHK("undefinedCode", 1'b1, accessErrorFlag)
    ackCount = 0;
    @(negedge clk);
    cmdLaunch = 1'b1;
    @(negedge clk);
    cmdLaunch = 1'b0;
    `CHK("refusedLaunch", 1'b1, cmdCompleteFlag)
    pulseClr();
    doCmd(8'h04, 8'h00, 16'h0003, 64'h0, 3'h1);
    doCmd(8'h07, 8'h00, 16'h0003, 64'h1234_5678_9abc_def0, 3'h5);
    doCmd(8'h04, 8'h00, 16'h0003, 64'h0, 3'h1);
    doCmd(8'h07, 8'h00, 16'h0003, 64'h0f0f_0f0f_0f0f_0f0f, 3'h5);
    doCmd(8'h07, 8'h00, 16'h0007, '1, 3'h5);
    doCmd(8'h07, 8'h00, 16'h0007, 64'h0000_1111_2222_3333, 3'h5);
    doCmd(8'h04, 8'h00, 16'h0008, 64'h0, 3'h1);
    doCmd(8'h07, 8'h00, 16'h0001, 64'h0, 3'h4);
    doCmd(8'h06, 8'hfe, 16'h0004, 64'h0, 3'h5);
    doCmd(8'h06, 8'h12, 16'h0000, 64'h0, 3'h5);
    protEnable = 1'b1;
    doCmd(8'h06, 8'hfe, 16'h0100, 64'h0, 3'h5);
    doCmd(8'h06, 8'hff, 16'h0100, 64'h5555_aaaa_5555_aaaa, 3'h5);
    injBad = 1'b1;
    doCmd(8'h06, 8'hff, 16'h0200, 64'h0123_4567_89ab_cdef, 3'h5);
    injBad = 1'b0;
    injFatal = 1'b1;
    doCmd(8'h04, 8'h00, 16'h0003, 64'h0, 3'h1);
    injFatal = 1'b0;
    // Random mix of codes, modes, faults and indices
    for (i = 0; i < 40; i++)
    begin
      r = $random(seed);
      onceCmdAllowed = r[2:0] != 3'h0;
      progCmdAllowed = r[5:3] != 3'h0;
      protEnable = r[6];
      injErr = r[9:7] == 3'h0;
      injFatal = r[12:10] == 3'h0;
      injBad = r[15:13] == 3'h0;
      doCmd(r[17:16] == 2'h0 ? 8'h04 : {7'h03, r[18]}, {7'h7f, r[19]},
        r[20] ? {12'h000, r[24:21]} : {r[31:25], 9'h000}, {$random(seed), $random(seed)},
        r[27:26] == 2'h0 ? r[30:28] : (r[17:16] == 2'h0 ? 3'h1 : 3'h5));
    end
    testDone();
  end
endmodule
`default_nettype wire
